// >>> rtl/dvrc_device.sv
// Drive end: decodes verify-ext and recalibrate, runs medium and head ports
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
module dvrc_device
    import dvrc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    dvrc_link_if.device      link,
    output logic             sec_req,
    output logic [47:0]      sec_lba,
    input  wire logic        sec_done,
    input  wire logic        sec_unc,
    output logic             seek_req,
    input  wire logic        seek_done,
    input  wire logic        seek_fail,
    output logic             sec_xfer
);
    import dvrc_pkg::*;

    typedef enum logic [2:0] {
        DVRC_IDLE,
        DVRC_VREQ,
        DVRC_VWAIT,
        DVRC_SREQ,
        DVRC_SWAIT
    } dvrc_dstate_t;

    // Command block, two levels per address/count byte
    logic [7:0]  cnt_cur_reg, cnt_cur_next;
    logic [7:0]  cnt_prv_reg, cnt_prv_next;
    logic [47:0] lba_reg, lba_next;
    logic [16:0] left_reg, left_next;
    // Status, error and read answer
    logic [7:0]  err_reg, err_next;
    logic [7:0]  st_reg, st_next;
    logic        hob_reg, hob_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        ack_reg, ack_next;
    logic        irq_reg, irq_next;
    dvrc_dstate_t state_reg, state_next;

    // Reads one of the three address bytes at the chosen level
    function automatic logic [7:0] lba_byte(input logic [47:0] a,
                                            input logic high_order_byte_select,
                                            input int   idx);
        lba_byte = high_order_byte_select ? a[8*(idx+3) +: 8] : a[8*idx +: 8];
    endfunction : lba_byte

    assign link.rdata = rdata_reg;
    assign link.rd_ack = ack_reg;
    assign link.intrq  = irq_reg;
    assign sec_req  = (state_reg == DVRC_VREQ);
    assign seek_req = (state_reg == DVRC_SREQ);
    assign sec_lba  = lba_reg;
    assign sec_xfer = 1'b0;

    // Next state of command block, status and sequencer
    always_comb begin
        cnt_cur_next = cnt_cur_reg;
        cnt_prv_next = cnt_prv_reg;
        lba_next     = lba_reg;
        left_next    = left_reg;
        err_next     = err_reg;
        st_next      = st_reg;
        hob_next     = hob_reg;
        rdata_next   = rdata_reg;
        ack_next     = 1'b0;
        irq_next     = irq_reg;
        state_next   = state_reg;
        if (link.rd_stb) begin
            ack_next = 1'b1;
            unique case (link.sel)
                DVRC_SEL_ERROR:  rdata_next = err_reg;
                DVRC_SEL_SCOUNT: rdata_next = hob_reg ? cnt_prv_reg
                                                      : cnt_cur_reg;
                DVRC_SEL_SNUM:   rdata_next = lba_byte(lba_reg, hob_reg, 0);
                DVRC_SEL_CYLLO:  rdata_next = lba_byte(lba_reg, hob_reg, 1);
                DVRC_SEL_CYLHI:  rdata_next = lba_byte(lba_reg, hob_reg, 2);
                DVRC_SEL_STATUS: begin
                    rdata_next = st_reg;
                    irq_next   = 1'b0;
                end
                default:         rdata_next = 8'h00;
            endcase
        end
        if (link.wr_stb && link.sel == DVRC_SEL_DEVCTL) begin
            hob_next = link.wdata[DVRC_DC_HOB];
        end
        if (link.wr_stb && state_reg == DVRC_IDLE) begin
            if (link.sel != DVRC_SEL_DEVCTL) begin
                hob_next = 1'b0;
            end
            unique case (link.sel)
                // Second write pushes first byte to the previous level
                DVRC_SEL_SCOUNT: begin
                    cnt_prv_next = cnt_cur_reg;
                    cnt_cur_next = link.wdata;
                end
                DVRC_SEL_SNUM: lba_next = {lba_reg[47:40], lba_reg[39:32],
                    lba_reg[7:0], lba_reg[23:16], lba_reg[15:8],
                    link.wdata};
                DVRC_SEL_CYLLO: lba_next = {lba_reg[47:40], lba_reg[15:8],
                    lba_reg[31:24], lba_reg[23:16], link.wdata,
                    lba_reg[7:0]};
                DVRC_SEL_CYLHI: lba_next = {lba_reg[23:16], lba_reg[39:32],
                    lba_reg[31:24], link.wdata, lba_reg[15:8],
                    lba_reg[7:0]};
                DVRC_SEL_CMD: begin
                    err_next = DVRC_ERROR_RESET;
                    irq_next = 1'b0;
                    st_next  = 8'h00;
                    st_next[DVRC_ST_BSY] = 1'b1;
                    if (link.wdata == DVRC_CMD_VERIFY_EXT) begin
                        left_next = ({cnt_prv_reg, cnt_cur_reg} == 16'h0000)
                            ? DVRC_ZERO_COUNT
                            : {1'b0, cnt_prv_reg, cnt_cur_reg};
                        state_next = DVRC_VREQ;
                    end else if (link.wdata[7:4] == DVRC_CMD_RECAL_HI) begin
                        state_next = DVRC_SREQ;
                    end else begin
                        // Unknown opcode is aborted at once
                        err_next[DVRC_ERR_ABT] = 1'b1;
                        st_next = DVRC_STATUS_RESET;
                        st_next[DVRC_ST_ERR] = 1'b1;
                        irq_next = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        unique case (state_reg)
            DVRC_IDLE: ;
            DVRC_VREQ: state_next = DVRC_VWAIT;
            DVRC_VWAIT: if (sec_done) begin
                if (sec_unc) begin
                    // Address of the failing sector stays in lba_reg
                    err_next[DVRC_ERR_UNC] = 1'b1;
                    st_next = DVRC_STATUS_RESET;
                    st_next[DVRC_ST_ERR] = 1'b1;
                    irq_next   = 1'b1;
                    state_next = DVRC_IDLE;
                end else if (left_reg == 17'h00001) begin
                    st_next    = DVRC_STATUS_RESET;
                    irq_next   = 1'b1;
                    left_next  = 17'h00000;
                    state_next = DVRC_IDLE;
                end else begin
                    left_next  = left_reg - 17'h00001;
                    lba_next   = lba_reg + 48'h000000000001;
                    state_next = DVRC_VREQ;
                end
            end
            DVRC_SREQ: state_next = DVRC_SWAIT;
            DVRC_SWAIT: if (seek_done) begin
                st_next = DVRC_STATUS_RESET;
                if (seek_fail) begin
                    err_next[DVRC_ERR_TZNF] = 1'b1;
                    st_next[DVRC_ST_ERR] = 1'b1;
                end
                irq_next   = 1'b1;
                state_next = DVRC_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_cur_reg <= 8'h00;
            cnt_prv_reg <= 8'h00;
            lba_reg     <= 48'h000000000000;
            left_reg    <= 17'h00000;
            err_reg     <= DVRC_ERROR_RESET;
            st_reg      <= DVRC_STATUS_RESET;
            hob_reg     <= 1'b0;
            rdata_reg   <= 8'h00;
            ack_reg     <= 1'b0;
            irq_reg     <= 1'b0;
            state_reg   <= DVRC_IDLE;
        end else begin
            cnt_cur_reg <= cnt_cur_next;
            cnt_prv_reg <= cnt_prv_next;
            lba_reg     <= lba_next;
            left_reg    <= left_next;
            err_reg     <= err_next;
            st_reg      <= st_next;
            hob_reg     <= hob_next;
            rdata_reg   <= rdata_next;
            ack_reg     <= ack_next;
            irq_reg     <= irq_next;
            state_reg   <= state_next;
        end
    end
endmodule : dvrc_device

// >>> rtl/dvrc_pkg.sv
// Package: constants and types shared by both ends of the verify/recalibrate link
package dvrc_pkg;
    // ==========================================================
    // Command block register selects (index on the link)
    localparam logic [3:0] DVRC_SEL_ERROR   = 4'h1; // Read: error flags
    localparam logic [3:0] DVRC_SEL_FEATURE = 4'h1; // Write: feature
    localparam logic [3:0] DVRC_SEL_SCOUNT  = 4'h2;
    localparam logic [3:0] DVRC_SEL_SNUM    = 4'h3;
    localparam logic [3:0] DVRC_SEL_CYLLO   = 4'h4;
    localparam logic [3:0] DVRC_SEL_CYLHI   = 4'h5;
    localparam logic [3:0] DVRC_SEL_DEVHEAD = 4'h6;
    localparam logic [3:0] DVRC_SEL_CMD     = 4'h7; // Write: command
    localparam logic [3:0] DVRC_SEL_STATUS  = 4'h7; // Read: status
    localparam logic [3:0] DVRC_SEL_DEVCTL  = 4'hE; // Write: device control

    // ==========================================================
    // Command codes
    localparam logic [7:0] DVRC_CMD_VERIFY_EXT = 8'h42;
    localparam logic [3:0] DVRC_CMD_RECAL_HI   = 4'h1;

    // ==========================================================
    // Field positions
    localparam int DVRC_ERR_UNC  = 6;
    localparam int DVRC_ERR_IDN  = 4;
    localparam int DVRC_ERR_ABT  = 2;
    localparam int DVRC_ERR_TZNF = 1;
    localparam int DVRC_ST_BSY   = 7;
    localparam int DVRC_ST_RDY   = 6;
    localparam int DVRC_ST_DF    = 5;
    localparam int DVRC_ST_DSC   = 4;
    localparam int DVRC_ST_DRQ   = 3;
    localparam int DVRC_ST_ERR   = 0;
    localparam int DVRC_DC_HOB   = 7;

    // ==========================================================
    // Reset values and counts
    localparam logic [7:0]  DVRC_STATUS_RESET = 8'h50;
    localparam logic [7:0]  DVRC_ERROR_RESET  = 8'h00;
    localparam logic [16:0] DVRC_ZERO_COUNT   = 17'h10000;

    // ==========================================================
    // Host-side AHB register offsets
    localparam logic [7:0] DVRC_A_LBA_LO  = 8'h00; // LBA 31:0
    localparam logic [7:0] DVRC_A_LBA_HI  = 8'h04; // LBA 47:32
    localparam logic [7:0] DVRC_A_COUNT   = 8'h08; // Sector count 15:0
    localparam logic [7:0] DVRC_A_CMD     = 8'h0C; // Write: start cmd
    localparam logic [7:0] DVRC_A_STAT    = 8'h10; // Status/error/busy
    localparam logic [7:0] DVRC_A_FAIL_LO = 8'h14; // Failing LBA 31:0
    localparam logic [7:0] DVRC_A_FAIL_HI = 8'h18; // Failing LBA 47:32

    typedef enum logic [1:0] {
        DVRC_HTRANS_IDLE   = 2'h0,
        DVRC_HTRANS_NONSEQ = 2'h2
    } dvrc_htrans_t;
endpackage : dvrc_pkg

// >>> rtl/dvrc_link_if.sv
// Interface: command block register port between host adapter and drive
interface dvrc_link_if (
    input wire logic hclk,
    input wire logic hresetn
);
    logic       wr_stb;   // One-cycle register write
    logic       rd_stb;   // One-cycle register read request
    logic [3:0] sel;      // Register select
    logic [7:0] wdata;    // Write byte
    logic [7:0] rdata;    // Read byte, valid with rd_ack
    logic       rd_ack;   // Read answer pulse
    logic       intrq;    // Command complete level

    modport device (
        input  wr_stb, rd_stb, sel, wdata,
        output rdata, rd_ack, intrq
    );
    modport host (
        output wr_stb, rd_stb, sel, wdata,
        input  rdata, rd_ack, intrq
    );
endinterface : dvrc_link_if

// >>> rtl/dvrc_host.sv
// Host adapter end: AHB-Lite slave registers driving the command block
module dvrc_host
    import dvrc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    dvrc_link_if.host        link
);
    import dvrc_pkg::*;

    typedef enum logic [3:0] {
        DVRC_H_IDLE, DVRC_H_WR, DVRC_H_CMD, DVRC_H_WAIT,
        DVRC_H_RERR, DVRC_H_RERRW, DVRC_H_RD, DVRC_H_RDW
    } dvrc_hstate_t;

    logic [47:0] lba_reg, lba_next, fail_reg, fail_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [7:0]  cmd_reg, cmd_next, st_reg, st_next, err_reg, err_next;
    logic [3:0]  step_reg, step_next;
    logic        wph_reg, wph_next, wr_reg, wr_next;
    logic [7:0]  adr_reg, adr_next;
    logic [31:0] rdat_reg, rdat_next;
    dvrc_hstate_t state_reg, state_next;

    logic        busy;
    logic [63:0] wr_bytes;
    logic [2:0]  rd_idx;
    assign busy = (state_reg != DVRC_H_IDLE);
    // Write order: each pair sends its previous-level byte first
    assign wr_bytes = {lba_reg[23:16], lba_reg[47:40], lba_reg[15:8],
        lba_reg[39:32], lba_reg[7:0], lba_reg[31:24], cnt_reg[7:0],
        cnt_reg[15:8]};
    // Readback byte within the chosen level
    assign rd_idx = (step_reg[3:1] > 3'h2) ? step_reg[3:1] - 3'h3
                                           : step_reg[3:1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdat_reg;

    // Link drive: one strobe per step
    always_comb begin
        link.wr_stb = 1'b0;
        link.rd_stb = 1'b0;
        link.sel    = DVRC_SEL_DEVCTL;
        link.wdata  = 8'h00;
        unique case (state_reg)
            DVRC_H_WR: begin
                link.wr_stb = 1'b1;
                link.sel    = DVRC_SEL_SCOUNT + {2'b00, step_reg[2:1]};
                link.wdata  = wr_bytes[8*step_reg[2:0] +: 8];
            end
            DVRC_H_CMD: begin
                link.wr_stb = 1'b1;
                link.sel    = DVRC_SEL_CMD;
                link.wdata  = cmd_reg;
            end
            DVRC_H_RERR: begin
                link.rd_stb = 1'b1;
                link.sel    = step_reg[0] ? DVRC_SEL_ERROR : DVRC_SEL_STATUS;
            end
            DVRC_H_RD: begin
                link.rd_stb = (step_reg[0] == 1'b1);
                link.wr_stb = (step_reg[0] == 1'b0);
                link.sel    = step_reg[0] ? (DVRC_SEL_SNUM + {1'b0, rd_idx})
                                          : DVRC_SEL_DEVCTL;
                link.wdata  = {step_reg[3:1] > 3'h2, 7'h00};
            end
            default: ;
        endcase
    end

    // Bus slave, command sequencer and result capture
    always_comb begin
        lba_next = lba_reg; fail_next = fail_reg; cnt_next = cnt_reg;
        cmd_next = cmd_reg; st_next = st_reg; err_next = err_reg;
        step_next = step_reg; state_next = state_reg; rdat_next = rdat_reg;
        wph_next = hsel && hready && htrans == DVRC_HTRANS_NONSEQ;
        wr_next  = hwrite;
        adr_next = haddr[7:0];
        if (wph_next && !hwrite) begin
            unique case (haddr[7:0])
                DVRC_A_LBA_LO:  rdat_next = lba_reg[31:0];
                DVRC_A_LBA_HI:  rdat_next = {16'h0000, lba_reg[47:32]};
                DVRC_A_COUNT:   rdat_next = {16'h0000, cnt_reg};
                DVRC_A_STAT:    rdat_next = {15'h0000, busy, err_reg, st_reg};
                DVRC_A_FAIL_LO: rdat_next = fail_reg[31:0];
                DVRC_A_FAIL_HI: rdat_next = {16'h0000, fail_reg[47:32]};
                default:        rdat_next = 32'h00000000;
            endcase
        end
        if (wph_reg && wr_reg && !busy) begin
            unique case (adr_reg)
                DVRC_A_LBA_LO: lba_next[31:0]  = hwdata;
                DVRC_A_LBA_HI: lba_next[47:32] = hwdata[15:0];
                DVRC_A_COUNT:  cnt_next = hwdata[15:0];
                DVRC_A_CMD: begin
                    cmd_next = hwdata[7:0]; step_next = 4'h0;
                    st_next[DVRC_ST_BSY] = 1'b1;
                    state_next = (hwdata[7:0] == DVRC_CMD_VERIFY_EXT)
                        ? DVRC_H_WR : DVRC_H_CMD;
                end
                default: ;
            endcase
        end
        unique case (state_reg)
            DVRC_H_IDLE: ;
            DVRC_H_WR: begin
                step_next = step_reg + 4'h1;
                if (step_reg == 4'h7) state_next = DVRC_H_CMD;
            end
            DVRC_H_CMD:  state_next = DVRC_H_WAIT;
            DVRC_H_WAIT: if (link.intrq) state_next = DVRC_H_RERR;
            DVRC_H_RERR: state_next = DVRC_H_RERRW;
            DVRC_H_RERRW: if (link.rd_ack && !step_reg[0]) begin
                // Status first; the read clears the completion level
                st_next = link.rdata;
                step_next = 4'h1;
                state_next = DVRC_H_RERR;
            end else if (link.rd_ack) begin
                err_next = link.rdata;
                step_next = 4'h0;
                state_next = DVRC_H_RD;
            end
            DVRC_H_RD: state_next = step_reg[0] ? DVRC_H_RDW : DVRC_H_RD;
            DVRC_H_RDW: if (link.rd_ack) begin
                // Reads go: 7:0, 15:8, 23:16, then 31:24, 39:32, 47:40
                fail_next[8*step_reg[3:1] +: 8] = link.rdata;
                state_next = (step_reg == 4'hB) ? DVRC_H_IDLE : DVRC_H_RD;
            end
            default: state_next = DVRC_H_IDLE;
        endcase
        if (state_reg == DVRC_H_RD && !step_reg[0]) step_next = step_reg + 4'h1;
        if (state_reg == DVRC_H_RDW && link.rd_ack) step_next = step_reg + 4'h1;
    end

    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lba_reg <= 48'h000000000000; fail_reg <= 48'h000000000000;
            cnt_reg <= 16'h0000; cmd_reg <= 8'h00;
            st_reg <= DVRC_STATUS_RESET;
            err_reg <= 8'h00; step_reg <= 4'h0; wph_reg <= 1'b0;
            wr_reg <= 1'b0; adr_reg <= 8'h00; rdat_reg <= 32'h00000000;
            state_reg <= DVRC_H_IDLE;
        end else begin
            lba_reg <= lba_next; fail_reg <= fail_next; cnt_reg <= cnt_next;
            cmd_reg <= cmd_next; st_reg <= st_next; err_reg <= err_next;
            step_reg <= step_next; wph_reg <= wph_next; wr_reg <= wr_next;
            adr_reg <= adr_next; rdat_reg <= rdat_next;
            state_reg <= state_next;
        end
    end
endmodule : dvrc_host

// >>> testbench/dvrc_link_props.sv
// Checker: command link handshake and decode properties
module dvrc_link_props
    import dvrc_pkg::*;
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [3:0] sel,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rd_ack,
    input wire logic       intrq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Last command byte seen on the link
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;

    // Next value of the command tracker
    always_comb begin
        cmd_next = cmd_reg;
        if (wr_stb && sel == DVRC_SEL_CMD) begin
            cmd_next = wdata;
        end
    end

    // Register the command tracker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_reg <= 8'h00;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Properties
    a_read_ack: assert property (rd_stb |=> rd_ack)
        else $error("read strobe without answer");
    a_ack_cause: assert property (rd_ack |-> $past(rd_stb))
        else $error("read answer without request");
    a_one_strobe: assert property (!(wr_stb && rd_stb))
        else $error("read and write in one cycle");
    a_rdata_holds: assert property (!rd_ack |-> $stable(rdata))
        else $error("read data moved without answer");
    a_cmd_clears: assert property (
        wr_stb && sel == DVRC_SEL_CMD && (wdata == DVRC_CMD_VERIFY_EXT
        || wdata[7:4] == DVRC_CMD_RECAL_HI) |=> !intrq)
        else $error("command write left completion set");
    a_status_clears: assert property (
        rd_stb && sel == DVRC_SEL_STATUS |=> !intrq)
        else $error("status read left completion set");
    a_done_not_busy: assert property (
        rd_stb && sel == DVRC_SEL_STATUS && intrq
        |=> !rdata[DVRC_ST_BSY])
        else $error("busy shown after completion");
    a_recal_accept: assert property (
        rd_stb && sel == DVRC_SEL_ERROR
        && cmd_reg[7:4] == DVRC_CMD_RECAL_HI
        |=> !rdata[DVRC_ERR_ABT] && !rdata[DVRC_ERR_UNC])
        else $error("recalibrate code refused");
    a_verify_accept: assert property (
        rd_stb && sel == DVRC_SEL_ERROR
        && cmd_reg == DVRC_CMD_VERIFY_EXT
        |=> !rdata[DVRC_ERR_ABT] && !rdata[DVRC_ERR_TZNF])
        else $error("verify refused or track flag set");

    c_verify: cover property (wr_stb && sel == DVRC_SEL_CMD
        && wdata == DVRC_CMD_VERIFY_EXT);
    c_recal: cover property (wr_stb && sel == DVRC_SEL_CMD
        && wdata[7:4] == DVRC_CMD_RECAL_HI);
    c_unc: cover property (rd_stb && sel == DVRC_SEL_ERROR
        ##1 rdata[DVRC_ERR_UNC]);
endmodule : dvrc_link_props

// >>> testbench/disk_verify_recalibrate_cmds_tb_top.sv
// Testbench: AHB host adapter and drive end joined over the link
`define DVRC_CHK(nm, ex, gt) \
    begin \
        comparisons++; \
        if ((gt) !== (ex)) begin \
            n_mismatch++; \
            $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); \
        end \
    end

module disk_verify_recalibrate_cmds_tb_top
    import dvrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sec_req, sec_done, sec_unc, sec_xfer;
    logic        seek_req, seek_done, seek_fail, fail_seek, xfer_seen;
    logic [47:0] sec_lba, first_lba, last_lba, bad_lba;
    int          n_mismatch, comparisons, n_sec, n_seek;

    // Clock at 40 MHz
    initial hclk = 1'b0;
    always #12.5 hclk = ~hclk;

    dvrc_link_if i_dvrc_link_if (.hclk(hclk), .hresetn(hresetn));
    dvrc_host i_dvrc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(i_dvrc_link_if));
    dvrc_device i_dvrc_device (.hclk(hclk), .hresetn(hresetn),
        .link(i_dvrc_link_if), .sec_req(sec_req), .sec_lba(sec_lba),
        .sec_done(sec_done), .sec_unc(sec_unc), .seek_req(seek_req),
        .seek_done(seek_done), .seek_fail(seek_fail), .sec_xfer(sec_xfer));
    dvrc_link_props i_dvrc_link_props (.hclk(hclk), .hresetn(hresetn),
        .wr_stb(i_dvrc_link_if.wr_stb), .rd_stb(i_dvrc_link_if.rd_stb),
        .sel(i_dvrc_link_if.sel), .wdata(i_dvrc_link_if.wdata),
        .rdata(i_dvrc_link_if.rdata), .rd_ack(i_dvrc_link_if.rd_ack),
        .intrq(i_dvrc_link_if.intrq));

    // Medium: logs each sector request and answers a cycle later
    always begin
        @(posedge hclk);
        if (sec_xfer === 1'b1) xfer_seen = 1'b1;
        if (sec_req === 1'b1) begin
            if (n_sec == 0) first_lba = sec_lba;
            last_lba = sec_lba;
            n_sec++;
            @(posedge hclk);
            sec_done <= 1'b1;
            sec_unc  <= (last_lba == bad_lba);
            @(posedge hclk);
            sec_done <= 1'b0;
            sec_unc  <= 1'b0;
        end
    end

    // Actuator: answers a seek three cycles later
    always begin
        @(posedge hclk);
        if (seek_req === 1'b1) begin
            n_seek++;
            repeat (3) @(posedge hclk);
            seek_done <= 1'b1;
            seek_fail <= fail_seek;
            @(posedge hclk);
            seek_done <= 1'b0;
            seek_fail <= 1'b0;
        end
    end

    task automatic end_sim;
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    // One AHB single transfer, waiting on hready in each phase
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= DVRC_HTRANS_NONSEQ;
        hwrite <= wr;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= DVRC_HTRANS_IDLE;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
        rd = hrdata;
        if (n >= 99) begin n_mismatch++; end_sim; end
    endtask : ahb

    task automatic wr32(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        ahb(1'b1, a, wd, d);
    endtask : wr32

    task automatic rd32(input logic [7:0] a, output logic [31:0] rd);
        ahb(1'b0, a, 32'h00000000, rd);
    endtask : rd32

    // Wait for busy to rise and then clear
    task automatic wait_done;
        logic [31:0] s;
        int n;
        n = 0;
        do begin rd32(DVRC_A_STAT, s); n++; end while (s[16] !== 1'b1 && n < 40);
        n = 0;
        do begin rd32(DVRC_A_STAT, s); n++; end while (s[16] !== 1'b0 && n < 30000);
        if (n >= 30000) begin n_mismatch++; end_sim; end
    endtask : wait_done

    // Load address and count, start a verify and wait for the end
    task automatic run_verify(input logic [47:0] lba, input logic [15:0] cnt,
                              input logic [47:0] bad);
        n_sec = 0;
        xfer_seen = 1'b0;
        bad_lba = bad;
        wr32(DVRC_A_LBA_LO, lba[31:0]);
        wr32(DVRC_A_LBA_HI, {16'h0000, lba[47:32]});
        wr32(DVRC_A_COUNT, {16'h0000, cnt});
        wr32(DVRC_A_CMD, {24'h000000, DVRC_CMD_VERIFY_EXT});
        wait_done;
    endtask : run_verify

    task automatic t_reset;
        logic [31:0] d;
        wr32(8'h1C, 32'hFFFFFFFF);
        rd32(DVRC_A_STAT, d);
        `DVRC_CHK("stat", {16'h0000, DVRC_ERROR_RESET, DVRC_STATUS_RESET}, d)
    endtask : t_reset

    // Bad sector one past a byte carry: stops there, reports it
    task automatic t_verify_unc;
        logic [31:0] d;
        run_verify(48'hA1B2C3D4E5FE, 16'h0005, 48'hA1B2C3D4E601);
        `DVRC_CHK("sectors", 4, n_sec)
        `DVRC_CHK("first", 48'hA1B2C3D4E5FE, first_lba)
        `DVRC_CHK("xfer", 1'b0, xfer_seen)
        rd32(DVRC_A_STAT, d);
        `DVRC_CHK("unc", 1'b1, d[8 + DVRC_ERR_UNC])
        `DVRC_CHK("err", 1'b1, d[DVRC_ST_ERR])
        rd32(DVRC_A_FAIL_LO, d);
        `DVRC_CHK("fail lo", 32'hC3D4E601, d)
        rd32(DVRC_A_FAIL_HI, d);
        `DVRC_CHK("fail hi", 32'h0000A1B2, d)
    endtask : t_verify_unc

    // Count with both bytes set, range crossing bit 40
    task automatic t_verify_wide;
        logic [31:0] d;
        run_verify(48'h00FFFFFFFF80, 16'h0102, 48'hFFFFFFFFFFFF);
        `DVRC_CHK("sectors", 258, n_sec)
        `DVRC_CHK("last", 48'h010000000081, last_lba)
        rd32(DVRC_A_STAT, d);
        `DVRC_CHK("error", 8'h00, d[15:8])
    endtask : t_verify_wide

    // Zero count runs past any reading of the count up to 0x2000, to the bad sector at 0x3000
    task automatic t_verify_zero;
        logic [31:0] d;
        run_verify(48'h000000001000, 16'h0000, 48'h000000003000);
        `DVRC_CHK("sectors", 32'h2001, n_sec)
        rd32(DVRC_A_FAIL_LO, d);
        `DVRC_CHK("fail lo", 32'h00003000, d)
    endtask : t_verify_zero

    // Recalibrate under several low nibbles, last one failing
    task automatic t_recal;
        logic [31:0] d;
        logic [3:0]  nib [4] = '{4'h0, 4'hA, 4'hF, 4'h3};
        for (int i = 0; i < 4; i++) begin
            n_seek = 0;
            n_sec = 0;
            fail_seek = (i == 3);
            wr32(DVRC_A_CMD, {24'h000000, DVRC_CMD_RECAL_HI, nib[i]});
            wait_done;
            rd32(DVRC_A_STAT, d);
            `DVRC_CHK("seeks", 1, n_seek)
            `DVRC_CHK("no sectors", 0, n_sec)
            `DVRC_CHK("abort", 1'b0, d[8 + DVRC_ERR_ABT])
            `DVRC_CHK("track0", fail_seek, d[8 + DVRC_ERR_TZNF])
        end
    endtask : t_recal

    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = DVRC_HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        sec_done = 1'b0;
        sec_unc = 1'b0;
        seek_done = 1'b0;
        seek_fail = 1'b0;
        fail_seek = 1'b0;
        bad_lba = 48'hFFFFFFFFFFFF;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_verify_unc;
        t_verify_wide;
        t_verify_zero;
        t_recal;
        end_sim;
    end
endmodule : disk_verify_recalibrate_cmds_tb_top
